// ---- verilog/isr_regs.sv ----
// identity and interrupt status register block with mask and interrupt output
//
// Implementation choice: the strobed register port.
module isr_regs
    import isr_pkg::*;
#(
    parameter logic [15:0] MODEL_CODE = MODEL_CODE_DEFAULT,
    parameter logic [15:0] REVISION = REVISION_DEFAULT
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [DATA_W-1:0] rdata_q,
    input wire logic fuse_write_done,
    input wire logic tx_lp_start_pulse,
    input wire logic tx_lp_stop_pulse,
    output logic energy_efficient_enable_q,
    output logic irq_q
);
    //------------------------------------------------------------
    // address decode
    //------------------------------------------------------------
    logic hit_id, hit_sts, hit_mask, hit_ctl;
    logic [DATA_W-1:0] clear_bits;
    logic [DATA_W-1:0] identity;
    logic [DATA_W-1:0] status;
    logic [DATA_W-1:0] mask_q;
    logic [DATA_W-1:0] mask_d;
    logic [DATA_W-1:0] rdata_d;
    logic ctl_d;
    logic fuse_flag, start_flag, stop_flag;
    logic eee_off;
    logic irq_d;

    // register hits
    assign hit_id = (addr == OFS_IDENTITY);
    assign hit_sts = (addr == OFS_INT_STATUS);
    assign hit_mask = (addr == OFS_INT_MASK);
    assign hit_ctl = (addr == OFS_CONTROL);
    assign clear_bits = (wr_en && hit_sts) ? wdata : '0;

    //------------------------------------------------------------
    // identity and status assembly
    //------------------------------------------------------------
    // fixed code high, revision low; no write path exists
    assign identity = {MODEL_CODE, REVISION};
    assign eee_off = ~energy_efficient_enable_q;

    // status word, reserved bits zero
    always_comb begin
        status = '0;
        status[BIT_FUSE_DONE] = fuse_flag;
        status[BIT_TX_LP_START] = start_flag;
        status[BIT_TX_LP_STOP] = stop_flag;
    end

    //------------------------------------------------------------
    // sticky flags
    //------------------------------------------------------------
    // level source re-sets while held; set wins over clear
    isr_sticky_bit u_fuse (
        .clk(clk),
        .reset(reset),
        .set_in(fuse_write_done),
        .clear_in(clear_bits[BIT_FUSE_DONE]),
        .hold_low(1'b0),
        .flag_q(fuse_flag)
    );

    // entry pulse latched, held low while eee disabled
    isr_sticky_bit u_start (
        .clk(clk),
        .reset(reset),
        .set_in(tx_lp_start_pulse),
        .clear_in(clear_bits[BIT_TX_LP_START]),
        .hold_low(eee_off),
        .flag_q(start_flag)
    );

    // exit pulse latched, held low while eee disabled
    isr_sticky_bit u_stop (
        .clk(clk),
        .reset(reset),
        .set_in(tx_lp_stop_pulse),
        .clear_in(clear_bits[BIT_TX_LP_STOP]),
        .hold_low(eee_off),
        .flag_q(stop_flag)
    );

    //------------------------------------------------------------
    // mask, control, read mux, interrupt
    //------------------------------------------------------------
    assign mask_d = (wr_en && hit_mask) ? (wdata & STATUS_IMPL_MASK) : mask_q;
    assign ctl_d = (wr_en && hit_ctl) ? wdata[BIT_EEE_ENABLE] : energy_efficient_enable_q;
    assign rdata_d = !rd_en ? '0 :
                     hit_id ? identity :
                     hit_sts ? status :
                     hit_mask ? mask_q :
                     hit_ctl ? {{(DATA_W-1){1'b0}}, energy_efficient_enable_q} : '0;
    assign irq_d = |(status & mask_q);

    // software-visible flops
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            mask_q <= MASK_RESET;
            energy_efficient_enable_q <= CONTROL_RESET[BIT_EEE_ENABLE];
            rdata_q <= '0;
            irq_q <= 1'b0;
        end else begin
            mask_q <= mask_d;
            energy_efficient_enable_q <= ctl_d;
            rdata_q <= rdata_d;
            irq_q <= irq_d;
        end
    end

    //------------------------------------------------------------
    // assertions
    //------------------------------------------------------------
    property p_id_fixed;
        @(posedge clk) disable iff (reset) rd_en && hit_id |=> rdata_q[31:16] == MODEL_CODE;
    endproperty
    a_id_fixed: assert property (p_id_fixed) else $error("model code wrong");

    property p_rev;
        @(posedge clk) disable iff (reset) rd_en && hit_id |=> rdata_q[15:0] == REVISION;
    endproperty
    a_rev: assert property (p_rev) else $error("revision wrong");

    property p_fuse_set;
        @(posedge clk) disable iff (reset) fuse_write_done |=> fuse_flag;
    endproperty
    a_fuse_set: assert property (p_fuse_set) else $error("fuse flag not set");

    property p_fuse_level;
        @(posedge clk) disable iff (reset) fuse_write_done [*2] |-> fuse_flag;
    endproperty
    a_fuse_level: assert property (p_fuse_level) else $error("fuse flag dropped under level");

    property p_start_set;
        @(posedge clk) disable iff (reset)
            tx_lp_start_pulse && energy_efficient_enable_q && ctl_d |=> start_flag;
    endproperty
    a_start_set: assert property (p_start_set) else $error("start flag not set");

    property p_stop_set;
        @(posedge clk) disable iff (reset)
            tx_lp_stop_pulse && energy_efficient_enable_q && ctl_d |=> stop_flag;
    endproperty
    a_stop_set: assert property (p_stop_set) else $error("stop flag not set");

    property p_eee_off;
        @(posedge clk) disable iff (reset) $past(eee_off) |-> !start_flag && !stop_flag;
    endproperty
    a_eee_off: assert property (p_eee_off) else $error("tx flags set while disabled");

    property p_sticky;
        @(posedge clk) disable iff (reset)
            start_flag && !clear_bits[BIT_TX_LP_START] && energy_efficient_enable_q && ctl_d |=> start_flag;
    endproperty
    a_sticky: assert property (p_sticky) else $error("start flag lost");

    property p_w1c;
        @(posedge clk) disable iff (reset)
            clear_bits[BIT_TX_LP_STOP] && !tx_lp_stop_pulse |=> !stop_flag;
    endproperty
    a_w1c: assert property (p_w1c) else $error("stop flag not cleared");

    property p_rsvd;
        @(posedge clk) disable iff (reset) rd_en && hit_sts |=> (rdata_q & ~STATUS_IMPL_MASK) == '0;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits nonzero");

    //------------------------------------------------------------
    // identity guards
    //------------------------------------------------------------
    // a write to the identity word must not disturb the word read after it
    property p_id_after_write;
        @(posedge clk) disable iff (reset)
            wr_en && hit_id ##[1:4] rd_en && hit_id |=> rdata_q == {MODEL_CODE, REVISION};
    endproperty
    a_id_after_write: assert property (p_id_after_write) else $error("identity changed by write");

    // the revision half is equally immune to writes
    property p_rev_after_write;
        @(posedge clk) disable iff (reset)
            wr_en && hit_id ##[1:4] rd_en && hit_id |=> rdata_q[15:0] == REVISION;
    endproperty
    a_rev_after_write: assert property (p_rev_after_write) else $error("revision changed by write");

    //------------------------------------------------------------
    // fuse flag guards
    //------------------------------------------------------------
    // after reset every flag starts clear, whatever its source is doing
    property p_flags_reset;
        @(posedge clk) disable iff (reset)
            $fell(reset) |-> !fuse_flag && !start_flag && !stop_flag;
    endproperty
    a_flags_reset: assert property (p_flags_reset) else $error("flag set straight after reset");

    // no fuse flag appears without its level
    property p_fuse_quiet;
        @(posedge clk) disable iff (reset)
            !fuse_flag && !fuse_write_done |=> !fuse_flag;
    endproperty
    a_fuse_quiet: assert property (p_fuse_quiet) else $error("fuse flag set without source");

    // once set, the fuse flag waits for software
    property p_fuse_sticky;
        @(posedge clk) disable iff (reset)
            fuse_flag && !clear_bits[BIT_FUSE_DONE] |=> fuse_flag;
    endproperty
    a_fuse_sticky: assert property (p_fuse_sticky) else $error("fuse flag lost");

    // a clear that meets a standing level loses, so the flag stays up
    property p_fuse_clear_loses;
        @(posedge clk) disable iff (reset)
            fuse_write_done && clear_bits[BIT_FUSE_DONE] |=> fuse_flag;
    endproperty
    a_fuse_clear_loses: assert property (p_fuse_clear_loses) else $error("fuse flag lost under level");

    // with the level gone a clear takes effect
    property p_fuse_clear;
        @(posedge clk) disable iff (reset)
            clear_bits[BIT_FUSE_DONE] && !fuse_write_done |=> !fuse_flag;
    endproperty
    a_fuse_clear: assert property (p_fuse_clear) else $error("fuse flag not cleared");

    //------------------------------------------------------------
    // low power flag guards
    //------------------------------------------------------------
    // the entry flag never sets without an entry pulse
    property p_start_quiet;
        @(posedge clk) disable iff (reset)
            !start_flag && !tx_lp_start_pulse |=> !start_flag;
    endproperty
    a_start_quiet: assert property (p_start_quiet) else $error("start flag set without pulse");

    // the exit flag never sets without an exit pulse
    property p_stop_quiet;
        @(posedge clk) disable iff (reset)
            !stop_flag && !tx_lp_stop_pulse |=> !stop_flag;
    endproperty
    a_stop_quiet: assert property (p_stop_quiet) else $error("stop flag set without pulse");

    // a disabled block drops an entry pulse in the cycle it arrives
    property p_start_gated;
        @(posedge clk) disable iff (reset)
            eee_off && tx_lp_start_pulse |=> !start_flag;
    endproperty
    a_start_gated: assert property (p_start_gated) else $error("start pulse taken while disabled");

    // a disabled block drops an exit pulse in the cycle it arrives
    property p_stop_gated;
        @(posedge clk) disable iff (reset)
            eee_off && tx_lp_stop_pulse |=> !stop_flag;
    endproperty
    a_stop_gated: assert property (p_stop_gated) else $error("stop pulse taken while disabled");

    // disabling empties both flags two edges on: one loads the bit, one gates
    property p_disable_clears;
        @(posedge clk) disable iff (reset)
            wr_en && hit_ctl && !wdata[BIT_EEE_ENABLE] |-> ##2 !start_flag && !stop_flag;
    endproperty
    a_disable_clears: assert property (p_disable_clears) else $error("tx flags kept after disable");

    // the exit flag waits for software while the block stays enabled
    property p_stop_sticky;
        @(posedge clk) disable iff (reset)
            stop_flag && !clear_bits[BIT_TX_LP_STOP] && !eee_off |=> stop_flag;
    endproperty
    a_stop_sticky: assert property (p_stop_sticky) else $error("stop flag lost");

    // clearing the entry flag works when no new pulse meets it
    property p_start_clear;
        @(posedge clk) disable iff (reset)
            clear_bits[BIT_TX_LP_START] && !tx_lp_start_pulse |=> !start_flag;
    endproperty
    a_start_clear: assert property (p_start_clear) else $error("start flag not cleared");

    //------------------------------------------------------------
    // read path and register write guards
    //------------------------------------------------------------
    // the fuse bit reads back as its flag stood in the read cycle
    property p_read_fuse;
        @(posedge clk) disable iff (reset)
            rd_en && hit_sts |=> rdata_q[BIT_FUSE_DONE] == $past(fuse_flag);
    endproperty
    a_read_fuse: assert property (p_read_fuse) else $error("fuse bit read wrong");

    // the entry bit reads back as its flag stood in the read cycle
    property p_read_start;
        @(posedge clk) disable iff (reset)
            rd_en && hit_sts |=> rdata_q[BIT_TX_LP_START] == $past(start_flag);
    endproperty
    a_read_start: assert property (p_read_start) else $error("start bit read wrong");

    // the exit bit reads back as its flag stood in the read cycle
    property p_read_stop;
        @(posedge clk) disable iff (reset)
            rd_en && hit_sts |=> rdata_q[BIT_TX_LP_STOP] == $past(stop_flag);
    endproperty
    a_read_stop: assert property (p_read_stop) else $error("stop bit read wrong");

    // the control word shows the enable bit as it stood in the read cycle
    property p_read_ctl;
        @(posedge clk) disable iff (reset)
            rd_en && hit_ctl |=> rdata_q[BIT_EEE_ENABLE] == $past(energy_efficient_enable_q);
    endproperty
    a_read_ctl: assert property (p_read_ctl) else $error("enable bit read wrong");

    // an address outside the map reads as zero
    property p_read_unmapped;
        @(posedge clk) disable iff (reset)
            rd_en && !hit_id && !hit_sts && !hit_mask && !hit_ctl |=> rdata_q == '0;
    endproperty
    a_read_unmapped: assert property (p_read_unmapped) else $error("unmapped read nonzero");

    // a written mask keeps only the implemented positions
    property p_mask_write;
        @(posedge clk) disable iff (reset)
            wr_en && hit_mask |=> mask_q == ($past(wdata) & STATUS_IMPL_MASK);
    endproperty
    a_mask_write: assert property (p_mask_write) else $error("mask write wrong");

    // a control write loads the enable bit on the next edge
    property p_ctl_write;
        @(posedge clk) disable iff (reset)
            wr_en && hit_ctl |=> energy_efficient_enable_q == $past(wdata[BIT_EEE_ENABLE]);
    endproperty
    a_ctl_write: assert property (p_ctl_write) else $error("enable bit write wrong");

    //------------------------------------------------------------
    // interrupt guards
    //------------------------------------------------------------
    // a latched flag that is masked in raises the line one edge later
    property p_irq_up;
        @(posedge clk) disable iff (reset)
            (status & mask_q) != '0 |=> irq_q;
    endproperty
    a_irq_up: assert property (p_irq_up) else $error("interrupt line not raised");

    // with every flag cleared or masked out the line drops one edge later
    property p_irq_down;
        @(posedge clk) disable iff (reset)
            (status & mask_q) == '0 |=> !irq_q;
    endproperty
    a_irq_down: assert property (p_irq_down) else $error("interrupt line stuck high");
endmodule : isr_regs

// ---- verilog/isr_pkg.sv ----
// package of register map, field positions and reset values for the identity and interrupt status block
//------------------------------------------------------------
// Functional notes
// - identity upper half holds fixed read-only model code; writes ignored.
// - identity lower half holds read-only silicon revision value set per part.
// - fuse-write-done flag sets when fuse programming finishes; resets to zero.
// - fuse-write-done comes from a level; stays set while fuse block holds it.
// - tx low power start flag sets when request delay expiry enters low power.
// - tx low power stop flag sets when removal delay expiry leaves low power.
// - both tx low power flags forced zero while energy efficient enable is clear.
// - tx low power flags latch single-cycle pulses until software clears them.
//------------------------------------------------------------
package isr_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam logic [11:0] OFS_IDENTITY = 12'h000;
    localparam logic [11:0] OFS_INT_STATUS = 12'h00c;
    localparam logic [11:0] OFS_INT_MASK = 12'h010;
    localparam logic [11:0] OFS_CONTROL = 12'h014;
    localparam int BIT_FUSE_DONE = 28;
    localparam int BIT_TX_LP_START = 26;
    localparam int BIT_TX_LP_STOP = 25;
    localparam int BIT_EEE_ENABLE = 0;
    localparam logic [31:0] STATUS_IMPL_MASK = 32'h1600_0000;
    localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
    localparam logic [31:0] MASK_RESET = 32'h0000_0000;
    localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
    localparam logic [15:0] MODEL_CODE_DEFAULT = 16'h5a5a; // arbitrary neutral value
    localparam logic [15:0] REVISION_DEFAULT = 16'h0001; // arbitrary neutral value
endpackage : isr_pkg

// ---- verilog/isr_sticky_bit.sv ----
// one sticky status bit with write-one-to-clear and hold-low gate
module isr_sticky_bit (
    input wire logic clk,
    input wire logic reset,
    input wire logic set_in,
    input wire logic clear_in,
    input wire logic hold_low,
    output logic flag_q
);
    logic flag_d;

    // set beats clear; hold_low beats both
    assign flag_d = hold_low ? 1'b0 : (set_in | (flag_q & ~clear_in));

    // flag flop
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
        end
    end
endmodule : isr_sticky_bit

// ---- bench/interrupt_status_and_id_regs_bench.sv ----
// self-checking bench for the identity and interrupt status register block
module interrupt_status_and_id_regs_bench
    import isr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    //------------------------------------------------------------
    // stimulus signals and counters
    //------------------------------------------------------------
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [11:0] addr = 12'h000;
    logic [31:0] wdata = 32'h0000_0000;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic fuse = 1'b0;
    logic lp_start = 1'b0;
    logic lp_stop = 1'b0;
    logic [31:0] rdata_q;
    logic eee_q;
    logic irq_q;
    logic [31:0] seed = 32'h48a6;
    logic [31:0] exp_sts;
    logic [31:0] clr;
    int miscompares = 0;
    int checks_done = 0;
    // free-running clock, 4 ns period
    always #2 clk = ~clk;
    isr_regs uut (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
        .rdata_q(rdata_q), .fuse_write_done(fuse), .tx_lp_start_pulse(lp_start), .tx_lp_stop_pulse(lp_stop),
        .energy_efficient_enable_q(eee_q), .irq_q(irq_q));
    //------------------------------------------------------------
    // helpers
    //------------------------------------------------------------
    // next value of the random sequence
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h8020_0003 : 32'h0);
    endfunction : lfsr
    // expected status after one random round: pulses set, then write-one clears
    function automatic logic [31:0] expect_sts(input logic [31:0] prev, input logic [31:0] s,
                                               input logic [31:0] c);
        return (prev | {5'h0, s[0], s[1], 25'h0}) & ~c;
    endfunction : expect_sts
    // compare seen against expected
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check
    // one-cycle register write
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        wr_en <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask : wr
    // one-cycle read, data taken in the following cycle
    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        @(posedge clk);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 check(rdata_q, e);
    endtask : rdchk
    // one-cycle event pulses
    task automatic pulse(input logic s, input logic p);
        @(posedge clk);
        lp_start <= s;
        lp_stop <= p;
        @(posedge clk);
        lp_start <= 1'b0;
        lp_stop <= 1'b0;
    endtask : pulse
    // verdict and end of run
    task automatic test_done();
        if (miscompares == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : test_done
    //------------------------------------------------------------
    // main sequence
    //------------------------------------------------------------
    initial begin
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        rdchk(OFS_IDENTITY, {MODEL_CODE_DEFAULT, REVISION_DEFAULT});
        wr(OFS_IDENTITY, 32'hffff_ffff);
        rdchk(OFS_IDENTITY, {MODEL_CODE_DEFAULT, REVISION_DEFAULT});
        rdchk(OFS_INT_STATUS, 32'h0);
        rdchk(12'h020, 32'h0);
        pulse(1'b1, 1'b1);
        rdchk(OFS_INT_STATUS, 32'h0);
        wr(OFS_INT_MASK, 32'hffff_ffff);
        rdchk(OFS_INT_MASK, STATUS_IMPL_MASK);
        wr(OFS_CONTROL, 32'h1);
        #1 check({31'h0, eee_q}, 32'h1);
        rdchk(OFS_CONTROL, 32'h1);
        pulse(1'b1, 1'b1);
        rdchk(OFS_INT_STATUS, 32'h0600_0000);
        check({31'h0, irq_q}, 32'h1);
        wr(OFS_CONTROL, 32'h0);
        rdchk(OFS_INT_STATUS, 32'h0);
        // fuse level: sets, survives a clear while high, goes on a second clear once the level drops
        @(posedge clk);
        fuse <= 1'b1;
        rdchk(OFS_INT_STATUS, 32'h1000_0000);
        wr(OFS_INT_STATUS, 32'h1000_0000);
        rdchk(OFS_INT_STATUS, 32'h1000_0000);
        @(posedge clk);
        fuse <= 1'b0;
        wr(OFS_INT_STATUS, 32'h1000_0000);
        rdchk(OFS_INT_STATUS, 32'h0);
        check({31'h0, irq_q}, 32'h0);
        // random pulses and random write-one-clear against a model
        wr(OFS_CONTROL, 32'h1);
        exp_sts = 32'h0;
        for (int i = 0; i < 40; i++) begin
            seed = lfsr(seed);
            pulse(seed[0], seed[1]);
            clr = {3'h0, seed[4], 1'b0, seed[3], seed[2], 25'h0} | (seed & 32'he800_ffff);
            wr(OFS_INT_STATUS, clr);
            exp_sts = expect_sts(exp_sts, seed, clr);
            rdchk(OFS_INT_STATUS, exp_sts);
            check({31'h0, irq_q}, {31'h0, |exp_sts});
        end
        // mid-run reset with every flag pending: all come back clear, enable off
        @(posedge clk);
        fuse <= 1'b1;
        pulse(1'b1, 1'b1);
        fuse <= 1'b0;
        @(posedge clk);
        reset <= 1'b1;
        @(posedge clk);
        reset <= 1'b0;
        rdchk(OFS_INT_STATUS, 32'h0);
        rdchk(OFS_CONTROL, 32'h0);
        check({31'h0, irq_q}, 32'h0);
        test_done();
    end
endmodule : interrupt_status_and_id_regs_bench
